/* File: hdl/brf_monitor.sv */
// Notes on behaviour
// - driver on, no current: open fault, full brake
// - open fault held until repair, driver cycle, key
// - movement after brake delay: not-set fault
// - reverse at interlock command: tiedown fault
// - tiedown clears: no reverse, throttle zero, neutral
// - reverse ends off-neutral: sequencing fault
// - sequencing clear needs neutral, interlock if option
// - reverse contacts agree: redundancy fault, all off
// - reverse held beyond limit: timeout fault
// - encoder out of range: encoder fault, key clears
// - current while brake off: driver-on fault
`include "brf_params.svh"
`timescale 1ns/1ps
`default_nettype none
module brf_monitor
   import brf_pkg::*;
#(
   parameter int ENGAGE_CYCLES = `BRF_ENGAGE_CYCLES // brake settle time in cycles
) (
   input wire logic i_mclk, // controller clock, 10 MHz
   input wire logic i_resetn, // async reset, active low
   input wire logic i_key_switch_input, // key switch pin, high = on
   input wire logic i_interlock, // interlock pin, high = commanded
   input wire logic i_throttle_active, // throttle off zero
   input wire logic i_direction_fwd, // forward selected
   input wire logic i_direction_rev, // reverse selected
   input wire logic i_emergency_reverse_no, // normally-open reverse contact
   input wire logic i_emergency_reverse_nc, // normally-closed reverse contact
   input wire logic i_brake_cmd, // brake driver commanded on (releases brake)
   input wire logic i_brake_current, // coil current sensed
   input wire logic i_motion, // vehicle movement sensed
   input wire logic i_encoder_switch_input, // encoder in range flag
   input wire logic i_reverse_release_option, // interlock must drop to clear
   input wire logic [31:0] i_reverse_limit, // reverse time limit in cycles
   output logic o_throttle_shutdown, // throttle held off
   output logic o_park_brake_shutdown, // brake driver forced off
   output logic o_full_braking_action, // full braking demand
   output logic o_motor_shutdown, // motor bridge off
   output logic o_all_shutdown, // every output off
   output logic [`BRF_NUM_FAULTS-1:0] o_fault_vector, // latched faults
   output logic [7:0] o_fault_code, // highest priority code, 0 = none
   output logic [7:0] o_beacon, // beacon pattern of that fault
   output logic o_user_category // shown fault is user category
);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisation: every pin passes two flops
   localparam int NSYNC = 12;
   logic [NSYNC-1:0] pins; // synchronised pins
   logic key, ilk, thr, dfw, drv, rno, rnc, bcmd, bcur, mot, enc, opt;
   brf_sync #(.WIDTH(NSYNC)) u_sync (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_async({i_key_switch_input, i_interlock, i_throttle_active, i_direction_fwd,
                i_direction_rev, i_emergency_reverse_no, i_emergency_reverse_nc,
                i_brake_cmd, i_brake_current, i_motion, i_encoder_switch_input,
                i_reverse_release_option}),
      .o_sync(pins)
   );
   assign {key, ilk, thr, dfw, drv, rno, rnc, bcmd, bcur, mot, enc, opt} = pins;

   logic neutral; // no throttle and no direction
   logic rev_on; // reverse commanded
   assign neutral = !thr && !dfw && !drv;
   assign rev_on = rno && !rnc;

   ////////////////////////////////////////////////////////////////////////////
   // edge history for key, interlock and brake driver
   logic key_d, ilk_d, bcmd_d; // last cycle's levels
   logic key_rise, ilk_rise, bcmd_fall; // one-cycle edges
   logic key_cycled, drv_cycled; // key went off, driver went off since open fault
   logic next_key_cycled, next_drv_cycled;
   assign key_rise = key && !key_d;
   assign ilk_rise = ilk && !ilk_d;
   assign bcmd_fall = !bcmd && bcmd_d;

   ////////////////////////////////////////////////////////////////////////////
   // brake engage timer and reverse timer
   logic [31:0] engage_cnt, next_engage_cnt; // cycles since brake commanded to set
   logic [31:0] rev_cnt, next_rev_cnt; // cycles reverse held
   brf_rev_type rev_state, next_rev_state; // reverse sequencing
   logic engaged; // settle time has passed
   assign engaged = (engage_cnt >= 32'(ENGAGE_CYCLES));

   logic [`BRF_NUM_FAULTS-1:0] flt, next_flt; // latched fault bits
   logic [1:0] warm, next_warm; // synchroniser fill after reset
   logic primed; // pins now show real levels
   // the synchroniser resets to zero, which looks like agreeing reverse contacts
   // and a bad encoder; sets wait until real pin levels have arrived
   assign primed = warm[1];

   // next-state logic
   always_comb begin
      next_key_cycled = key_cycled;
      next_drv_cycled = drv_cycled;
      next_engage_cnt = engage_cnt;
      next_rev_cnt = rev_cnt;
      next_rev_state = rev_state;
      next_flt = flt;
      next_warm = {warm[0], 1'b1};
      // key-off seen: armed to clear on the next key-on
      if (!key) begin
         next_key_cycled = 1'b1;
      end else if (key_rise) begin
         next_key_cycled = 1'b0;
      end
      // driver cycle tracked only while the open fault stands
      if (!flt[`BRF_BIT_BRAKE_OPEN]) begin
         next_drv_cycled = 1'b0;
      end else if (bcmd_fall) begin
         next_drv_cycled = 1'b1;
      end
      // brake set timer runs while driver is off
      if (bcmd) begin
         next_engage_cnt = '0;
      end else if (!engaged) begin
         next_engage_cnt = engage_cnt + 32'h1;
      end
      // reverse duration timer
      if (!rev_on) begin
         next_rev_cnt = '0;
      end else if (rev_cnt != 32'hffffffff) begin
         next_rev_cnt = rev_cnt + 32'h1;
      end
      // reverse event sequencing
      case (rev_state)
         REV_IDLE: begin
            if (rev_on) begin
               next_rev_state = REV_ACTIVE;
            end
         end
         REV_ACTIVE: begin
            if (!rev_on) begin
               next_rev_state = REV_DONE;
            end
         end
         default: begin
            next_rev_state = REV_IDLE;
         end
      endcase

      // clears first, then sets, so a cause present now always wins
      if (key_rise && key_cycled) begin
         next_flt[`BRF_BIT_BRAKE_ON] = 1'b0;
         next_flt[`BRF_BIT_ENCODER] = 1'b0;
         next_flt[`BRF_BIT_REDUND] = 1'b0;
         next_flt[`BRF_BIT_NOT_SET] = 1'b0;
         if (drv_cycled) begin
            next_flt[`BRF_BIT_BRAKE_OPEN] = 1'b0;
         end
      end
      if (thr || ilk_rise) begin
         next_flt[`BRF_BIT_NOT_SET] = 1'b0;
      end
      if (!rev_on && neutral) begin
         next_flt[`BRF_BIT_TIEDOWN] = 1'b0;
      end
      if (neutral && (!opt || !ilk)) begin
         next_flt[`BRF_BIT_REV_SEQ] = 1'b0;
      end
      if (!rev_on) begin
         next_flt[`BRF_BIT_TIMEOUT] = 1'b0;
      end

      // set conditions, held off until the synchroniser is full
      if (primed) begin
         if (bcmd && !bcur) begin
            next_flt[`BRF_BIT_BRAKE_OPEN] = 1'b1;
         end
         if (!bcmd && bcur) begin
            next_flt[`BRF_BIT_BRAKE_ON] = 1'b1;
         end
         if (!bcmd && engaged && mot) begin
            next_flt[`BRF_BIT_NOT_SET] = 1'b1;
         end
         if (ilk_rise && rev_on) begin
            next_flt[`BRF_BIT_TIEDOWN] = 1'b1;
         end
         if (rev_state == REV_DONE && !(neutral && (!opt || !ilk))) begin
            next_flt[`BRF_BIT_REV_SEQ] = 1'b1;
         end
         if (rno == rnc) begin
            next_flt[`BRF_BIT_REDUND] = 1'b1;
         end
         if (rev_on && rev_cnt >= i_reverse_limit) begin
            next_flt[`BRF_BIT_TIMEOUT] = 1'b1;
         end
         if (!enc) begin
            next_flt[`BRF_BIT_ENCODER] = 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         key_d <= 1'b0;
         ilk_d <= 1'b0;
         bcmd_d <= 1'b0;
         key_cycled <= 1'b1;
         drv_cycled <= 1'b0;
         engage_cnt <= '0;
         rev_cnt <= '0;
         rev_state <= REV_IDLE;
         flt <= '0;
         warm <= 2'h0;
      end else begin
         key_d <= key;
         ilk_d <= ilk;
         bcmd_d <= bcmd;
         key_cycled <= next_key_cycled;
         drv_cycled <= next_drv_cycled;
         engage_cnt <= next_engage_cnt;
         rev_cnt <= next_rev_cnt;
         rev_state <= next_rev_state;
         flt <= next_flt;
         warm <= next_warm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shutdown decode and reported code, registered
   logic next_thr_sd, next_brk_sd, next_full, next_mot_sd, next_all;
   logic [7:0] next_code, next_beacon;
   logic next_user;
   // priority: redundancy first since it kills everything
   always_comb begin
      next_all = flt[`BRF_BIT_REDUND];
      next_mot_sd = flt[`BRF_BIT_ENCODER] || next_all;
      next_full = flt[`BRF_BIT_BRAKE_OPEN] || flt[`BRF_BIT_BRAKE_ON];
      next_brk_sd = |flt; // every fault here sheds the brake driver
      next_thr_sd = |flt;
      next_code = 8'h00;
      next_beacon = 8'h00;
      next_user = 1'b0;
      if (flt[`BRF_BIT_REDUND]) begin
         next_code = `BRF_CODE_REDUND;
         next_beacon = `BRF_BEACON_REDUND;
      end else if (flt[`BRF_BIT_ENCODER]) begin
         next_code = `BRF_CODE_ENCODER;
         next_beacon = `BRF_BEACON_ENCODER;
      end else if (flt[`BRF_BIT_BRAKE_ON]) begin
         next_code = `BRF_CODE_BRAKE_ON;
         next_beacon = `BRF_BEACON_BRAKE_ON;
      end else if (flt[`BRF_BIT_BRAKE_OPEN]) begin
         next_code = `BRF_CODE_BRAKE_OPEN;
         next_beacon = `BRF_BEACON_BRAKE_OPEN;
      end else if (flt[`BRF_BIT_NOT_SET]) begin
         next_code = `BRF_CODE_NOT_SET;
         next_beacon = `BRF_BEACON_NOT_SET;
      end else if (flt[`BRF_BIT_TIEDOWN]) begin
         next_code = `BRF_CODE_TIEDOWN;
         next_beacon = `BRF_BEACON_TIEDOWN;
         next_user = 1'b1;
      end else if (flt[`BRF_BIT_REV_SEQ]) begin
         next_code = `BRF_CODE_REV_SEQ;
         next_beacon = `BRF_BEACON_REV_SEQ;
         next_user = 1'b1;
      end else if (flt[`BRF_BIT_TIMEOUT]) begin
         next_code = `BRF_CODE_TIMEOUT;
         next_beacon = `BRF_BEACON_TIMEOUT;
         next_user = 1'b1;
      end
   end

   // output registers
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_throttle_shutdown <= 1'b0;
         o_park_brake_shutdown <= 1'b0;
         o_full_braking_action <= 1'b0;
         o_motor_shutdown <= 1'b0;
         o_all_shutdown <= 1'b0;
         o_fault_vector <= '0;
         o_fault_code <= 8'h00;
         o_beacon <= 8'h00;
         o_user_category <= 1'b0;
      end else begin
         o_throttle_shutdown <= next_thr_sd;
         o_park_brake_shutdown <= next_brk_sd;
         o_full_braking_action <= next_full;
         o_motor_shutdown <= next_mot_sd;
         o_all_shutdown <= next_all;
         o_fault_vector <= flt;
         o_fault_code <= next_code;
         o_beacon <= next_beacon;
         o_user_category <= next_user;
      end
   end
endmodule // brf_monitor
`default_nettype wire

/* File: hdl/brf_params.svh */
`ifndef BRF_PARAMS_SVH
`define BRF_PARAMS_SVH
// fault display codes: decimal gauge numbers written in hex, except tiedown 3b and redundancy 0c
`define BRF_CODE_BRAKE_OPEN 8'h24
`define BRF_CODE_BRAKE_ON 8'h25
`define BRF_CODE_NOT_SET 8'h26
`define BRF_CODE_TIEDOWN 8'h3b
`define BRF_CODE_REV_SEQ 8'h68
`define BRF_CODE_REDUND 8'h0c
`define BRF_CODE_TIMEOUT 8'h69
`define BRF_CODE_ENCODER 8'h12
// beacon patterns: high nibble long flashes, low nibble short flashes
`define BRF_BEACON_BRAKE_OPEN 8'h25
`define BRF_BEACON_BRAKE_ON 8'h26
`define BRF_BEACON_NOT_SET 8'h26
`define BRF_BEACON_TIEDOWN 8'h59
`define BRF_BEACON_REV_SEQ 8'h1a
`define BRF_BEACON_REDUND 8'h34
`define BRF_BEACON_TIMEOUT 8'h1b
`define BRF_BEACON_ENCODER 8'h32
// status-bit index per fault, one bit each in o_fault_vector
`define BRF_BIT_BRAKE_OPEN 0
`define BRF_BIT_BRAKE_ON 1
`define BRF_BIT_NOT_SET 2
`define BRF_BIT_TIEDOWN 3
`define BRF_BIT_REV_SEQ 4
`define BRF_BIT_REDUND 5
`define BRF_BIT_TIMEOUT 6
`define BRF_BIT_ENCODER 7
`define BRF_NUM_FAULTS 8
// brake engagement delay: 200 ms at 100 ns per cycle
`define BRF_ENGAGE_MS 200
`define BRF_CLK_NS 100
`define BRF_ENGAGE_CYCLES ((`BRF_ENGAGE_MS * 1000000) / `BRF_CLK_NS)
`endif

/* File: hdl/brf_pkg.sv */
package brf_pkg;
   // emergency reverse sequencing
   typedef enum logic [1:0] {
      REV_IDLE,
      REV_ACTIVE,
      REV_DONE
   } brf_rev_type;
   // fault category reported
   typedef enum logic [0:0] {
      CAT_SYSTEM,
      CAT_USER
   } brf_cat_type;
endpackage

/* File: hdl/brf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin-level inputs
module brf_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_mclk, // controller clock
   input wire logic i_resetn, // async reset, active low
   input wire logic [WIDTH-1:0] i_async, // raw pin levels
   output logic [WIDTH-1:0] o_sync // synchronised levels
);
   logic [WIDTH-1:0] stage1; // first stage, read only by stage two
   logic [WIDTH-1:0] stage2; // second stage
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
      end
   end
   assign o_sync = stage2;
endmodule // brf_sync
`default_nettype wire

/* File: verif/brf_monitor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module brf_monitor_asserts #(
   parameter int ENGAGE_CYCLES = 10 // brake settle time in cycles
) (
   input wire logic i_mclk, // controller clock
   input wire logic i_resetn, // async reset, active low
   input wire logic i_throttle_active, // throttle off zero
   input wire logic i_direction_fwd, // forward selected
   input wire logic i_direction_rev, // reverse selected
   input wire logic i_emergency_reverse_no, // open contact
   input wire logic i_emergency_reverse_nc, // closed contact
   input wire logic i_interlock, // interlock pin
   input wire logic i_brake_cmd, // brake driver on
   input wire logic i_brake_current, // coil current
   input wire logic i_encoder_switch_input, // encoder in range
   input wire logic [31:0] i_reverse_limit, // reverse limit
   input wire logic o_throttle_shutdown, // throttle held off
   input wire logic o_park_brake_shutdown, // brake forced off
   input wire logic o_full_braking_action, // full braking
   input wire logic o_motor_shutdown, // motor off
   input wire logic o_all_shutdown, // all off
   input wire logic [7:0] o_fault_vector // latched faults
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   //////////////////////////////////////////
   // reverse request seen at the pins
   logic rev_on;
   logic [31:0] rev_cnt; // cycles the request has stood
   logic [31:0] next_rev_cnt;
   assign rev_on = i_emergency_reverse_no & ~i_emergency_reverse_nc;
   // counter restarts on release so a new press gets the whole limit
   always_comb begin
      next_rev_cnt = rev_on ? rev_cnt + 32'h1 : 32'h0;
   end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rev_cnt <= 32'h0;
      end else begin
         rev_cnt <= next_rev_cnt;
      end
   end
   sequence rev_end_s;
      rev_on ##1 !rev_on;
   endsequence
   //////////////////////////////////////////
   open_fault_a: assert property (
      i_brake_cmd && !i_brake_current |-> ##[1:6] (o_fault_vector[0] &&
      o_full_braking_action && o_park_brake_shutdown && o_throttle_shutdown))
      else $error("open coil fault missing");
   open_hold_a: assert property (
      (o_fault_vector[0] && i_brake_cmd && !i_brake_current)[*4] |=> o_fault_vector[0])
      else $error("open coil fault dropped");
   driver_on_a: assert property (
      !i_brake_cmd && i_brake_current |-> ##[1:6] (o_fault_vector[1] && o_full_braking_action))
      else $error("driver on fault missing");
   tiedown_set_a: assert property (
      $rose(i_interlock) && rev_on |-> ##[2:6] (o_fault_vector[3] &&
      o_throttle_shutdown && o_park_brake_shutdown))
      else $error("tiedown fault missing");
   tiedown_hold_a: assert property (
      (o_fault_vector[3] && (i_throttle_active || i_direction_fwd || i_direction_rev ||
      rev_on))[*4] |=> o_fault_vector[3])
      else $error("tiedown fault cleared early");
   rev_seq_a: assert property (
      rev_end_s ##0 (i_throttle_active || i_direction_fwd || i_direction_rev) |->
      ##[2:7] o_fault_vector[4])
      else $error("sequencing fault missing");
   redund_set_a: assert property (
      i_emergency_reverse_no == i_emergency_reverse_nc |-> ##[1:6]
      (o_fault_vector[5] && o_all_shutdown && o_motor_shutdown))
      else $error("redundancy fault missing");
   timeout_set_a: assert property (
      rev_cnt == i_reverse_limit + 32'h8 |-> o_fault_vector[6])
      else $error("timeout fault missing");
   timeout_clr_a: assert property (
      rev_end_s |-> ##[1:6] !o_fault_vector[6])
      else $error("timeout fault stuck");
   encoder_set_a: assert property (
      !i_encoder_switch_input |-> ##[1:6] (o_fault_vector[7] && o_motor_shutdown &&
      o_park_brake_shutdown))
      else $error("encoder fault missing");
endmodule // brf_monitor_asserts
bind brf_monitor brf_monitor_asserts #(.ENGAGE_CYCLES(ENGAGE_CYCLES)) u_brf_asserts (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_throttle_active(i_throttle_active),
   .i_direction_fwd(i_direction_fwd), .i_direction_rev(i_direction_rev),
   .i_emergency_reverse_no(i_emergency_reverse_no),
   .i_emergency_reverse_nc(i_emergency_reverse_nc), .i_interlock(i_interlock),
   .i_brake_cmd(i_brake_cmd), .i_brake_current(i_brake_current),
   .i_encoder_switch_input(i_encoder_switch_input), .i_reverse_limit(i_reverse_limit),
   .o_throttle_shutdown(o_throttle_shutdown), .o_park_brake_shutdown(o_park_brake_shutdown),
   .o_full_braking_action(o_full_braking_action), .o_motor_shutdown(o_motor_shutdown),
   .o_all_shutdown(o_all_shutdown), .o_fault_vector(o_fault_vector));
`default_nettype wire

/* File: verif/brf_vehicle_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brf_vehicle_model (
   input wire logic i_brake_cmd, // brake driver on
   input wire logic i_coil_open, // break the coil circuit
   input wire logic i_coil_short, // short the driver
   input wire logic i_rev_press, // reverse button pressed
   input wire logic i_contact_bad, // contacts stuck together
   input wire logic i_enc_bad, // encoder out of range
   output logic o_brake_current, // sensed coil current
   output logic o_rev_no, // open contact
   output logic o_rev_nc, // closed contact
   output logic o_encoder_ok // encoder in range
);
   //////////////////////////////////////////
   // coil carries current when driven and whole, or whenever the driver is shorted; repair restores it
   assign o_brake_current = (i_brake_cmd & ~i_coil_open) | i_coil_short;
   // healthy contacts always disagree; a stuck pair makes them agree
   assign o_rev_no = i_rev_press;
   assign o_rev_nc = ~i_rev_press ^ i_contact_bad;
   assign o_encoder_ok = ~i_enc_bad;
endmodule // brf_vehicle_model
`default_nettype wire

/* File: verif/brf_monitor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module brf_monitor_tb_top;
   logic i_mclk, i_resetn, key, ilock, thr, fwd, rvs, brake_cmd, motion, opt;
   logic coil_open, coil_short, rev_press, contact_bad, enc_bad;
   logic cur, rev_no, rev_nc, enc_ok, ts, pbs, fb, ms, as, ucat;
   logic [7:0] vec, code, beacon;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   //////////////////////////////////////////
   brf_monitor #(.ENGAGE_CYCLES(10)) DUT (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_key_switch_input(key),
      .i_interlock(ilock), .i_throttle_active(thr), .i_direction_fwd(fwd),
      .i_direction_rev(rvs), .i_emergency_reverse_no(rev_no),
      .i_emergency_reverse_nc(rev_nc), .i_brake_cmd(brake_cmd), .i_brake_current(cur),
      .i_motion(motion), .i_encoder_switch_input(enc_ok), .i_reverse_release_option(opt),
      .i_reverse_limit(32'h3c), .o_throttle_shutdown(ts), .o_park_brake_shutdown(pbs),
      .o_full_braking_action(fb), .o_motor_shutdown(ms), .o_all_shutdown(as),
      .o_fault_vector(vec), .o_fault_code(code), .o_beacon(beacon), .o_user_category(ucat));
   brf_vehicle_model u_far (
      .i_brake_cmd(brake_cmd), .i_coil_open(coil_open), .i_coil_short(coil_short),
      .i_rev_press(rev_press), .i_contact_bad(contact_bad), .i_enc_bad(enc_bad),
      .o_brake_current(cur), .o_rev_no(rev_no), .o_rev_nc(rev_nc), .o_encoder_ok(enc_ok));
   //////////////////////////////////////////
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   task automatic give_verdict;
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // a stuck design must not hold the run forever
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         give_verdict();
      end
   end
   // inputs always change 10 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #10;
   endtask
   // seven cycles cover the sync, latch and output stages
   task automatic look(input logic [7:0] v, input logic [7:0] c);
      step(7);
      `CHK("fault vector", v, vec)
      `CHK("fault code", c, code)
      `CHK("brake shutdown", v != 8'h00, pbs)
   endtask
   task automatic key_cycle;
      key = 1'b0;
      step(4);
      key = 1'b1;
      step(1);
   endtask
   //////////////////////////////////////////
   initial begin
      {i_resetn, ilock, thr, fwd, rvs, brake_cmd, motion, opt} = '0;
      {coil_open, coil_short, rev_press, contact_bad, enc_bad} = '0;
      key = 1'b1;
      step(16);
      i_resetn = 1'b1;
      look(8'h00, 8'h00);
      brake_cmd = 1'b1;
      coil_open = 1'b1;
      look(8'h01, 8'h24);
      `CHK("full brake", 1'b1, fb)
      `CHK("throttle shutdown", 1'b1, ts)
      `CHK("beacon", 8'h25, beacon)
      coil_open = 1'b0;
      key_cycle();
      look(8'h01, 8'h24);
      brake_cmd = 1'b0;
      step(1);
      key_cycle();
      look(8'h00, 8'h00);
      coil_short = 1'b1;
      look(8'h02, 8'h25);
      `CHK("beacon", 8'h26, beacon)
      coil_short = 1'b0;
      key_cycle();
      look(8'h00, 8'h00);
      // movement inside the engage delay is allowed
      brake_cmd = 1'b1;
      step(2);
      brake_cmd = 1'b0;
      step(3);
      motion = 1'b1;
      step(3);
      motion = 1'b0;
      look(8'h00, 8'h00);
      step(12);
      motion = 1'b1;
      look(8'h04, 8'h26);
      `CHK("throttle shutdown", 1'b1, ts)
      `CHK("beacon", 8'h26, beacon)
      motion = 1'b0;
      thr = 1'b1;
      look(8'h00, 8'h00);
      thr = 1'b0;
      rev_press = 1'b1;
      step(2);
      ilock = 1'b1;
      look(8'h08, 8'h3b);
      `CHK("user category", 1'b1, ucat)
      `CHK("throttle shutdown", 1'b1, ts)
      `CHK("beacon", 8'h59, beacon)
      look(8'h08, 8'h3b);
      rev_press = 1'b0;
      look(8'h00, 8'h00);
      for (int o = 0; o < 2; o++) begin
         opt = o[0];
         ilock = 1'b1;
         {fwd, rvs} = o ? 2'h1 : 2'h2;
         step(1);
         rev_press = 1'b1;
         step(4);
         rev_press = 1'b0;
         look(8'h10, 8'h68);
         `CHK("user category", 1'b1, ucat)
         `CHK("beacon", 8'h1a, beacon)
         {fwd, rvs} = 2'h0;
         look(o ? 8'h10 : 8'h00, o ? 8'h68 : 8'h00);
         ilock = 1'b0;
         look(8'h00, 8'h00);
      end
      rev_press = 1'b1;
      step(62);
      look(8'h40, 8'h69);
      `CHK("throttle shutdown", 1'b1, ts)
      `CHK("beacon", 8'h1b, beacon)
      rev_press = 1'b0;
      look(8'h00, 8'h00);
      contact_bad = 1'b1;
      look(8'h20, 8'h0c);
      `CHK("all shutdown", 1'b1, as)
      `CHK("beacon", 8'h34, beacon)
      contact_bad = 1'b0;
      look(8'h20, 8'h0c);
      key_cycle();
      look(8'h00, 8'h00);
      enc_bad = 1'b1;
      look(8'h80, 8'h12);
      `CHK("motor shutdown", 1'b1, ms)
      `CHK("beacon", 8'h32, beacon)
      enc_bad = 1'b0;
      look(8'h80, 8'h12);
      key_cycle();
      look(8'h00, 8'h00);
      give_verdict();
   end
endmodule // brf_monitor_tb_top
`default_nettype wire
